// >>> hdl/rst_pkg.sv
// Purpose: Shared constants for the reset source and clock select block
// Assumes: Single 40 MHz system clock
// Notes:   Source bit positions index the enable and status vectors
package rst_pkg;
  localparam int unsigned NUM_SRC     = 6;
  localparam int unsigned SRC_SUPPLY  = 0;
  localparam int unsigned SRC_WDOG    = 1;
  localparam int unsigned SRC_MCLK    = 2;
  localparam int unsigned SRC_CMP0    = 3;
  localparam int unsigned SRC_SOFT    = 4;
  localparam int unsigned SRC_PIN     = 5;
  // Software may mask only watchdog, missing clock, comparator, soft reset
  localparam logic [5:0]  MASKABLE    = 6'h1E;
  localparam logic [5:0]  EN_RESET    = 6'h3F;
  localparam logic        CLK_INT     = 1'h0;
  localparam logic        CLK_EXT     = 1'h1;
  // Minimum time the reset pin is driven after sources clear
  localparam int unsigned STRETCH_NS  = 100;
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  // Cycles the pin source stays ignored after own drive ends; covers the
  // lag of the pin filter so a released pin cannot re-trigger a reset
  localparam int unsigned ECHO_CYC    = 6;
endpackage

// >>> hdl/rst_sync_if.sv
// Purpose: Carries synchronised pin levels from the filter to the top
// Assumes: Both ends on clk_i
// Notes:   One signal per external level
`timescale 1ns/1ps
interface rst_sync_if;
  logic pin_rst;
  logic mon_en;
  modport src (output pin_rst, output mon_en);
  modport dst (input pin_rst, input mon_en);
endinterface

// >>> hdl/pin_filter.sv
// Purpose: Three-stage synchroniser for the reset pin and monitor strap
// Assumes: Inputs asynchronous to clk_i
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
module pin_filter (
  input  wire logic   clk_i,
  input  wire logic   rst_n,
  input  wire logic   pin_rst_n_i,
  input  wire logic   mon_en_i,
  rst_sync_if.src     sync
);
  logic [2:0] rst_sh;
  logic [2:0] mon_sh;
  logic [2:0] next_rst_sh;
  logic [2:0] next_mon_sh;
  logic       pin_lvl;
  logic       mon_lvl;
  logic       next_pin_lvl;
  logic       next_mon_lvl;

  // Shift chains; stage one feeds stage two only
  always_comb begin
    next_rst_sh  = {rst_sh[1:0], ~pin_rst_n_i};
    next_mon_sh  = {mon_sh[1:0], mon_en_i};
    next_pin_lvl = (rst_sh[2] == rst_sh[1]) ? rst_sh[2] : pin_lvl;
    next_mon_lvl = (mon_sh[2] == mon_sh[1]) ? mon_sh[2] : mon_lvl;
  end

  // Reset value treats the pin as asserted, so release is clean
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_sh  <= 3'h7;
      mon_sh  <= 3'h0;
      pin_lvl <= 1'h1;
      mon_lvl <= 1'h0;
    end else begin
      rst_sh  <= next_rst_sh;
      mon_sh  <= next_mon_sh;
      pin_lvl <= next_pin_lvl;
      mon_lvl <= next_mon_lvl;
    end
  end

  assign sync.pin_rst = pin_lvl;
  assign sync.mon_en  = mon_lvl;
endmodule

// >>> hdl/reset_source_and_clock_select.sv
// Purpose: Combines reset sources, drives the reset pin, selects sysclk
// Assumes: Sources on clk_i except the pin and strap, which are filtered
// Notes:   Enables and lock are plain ports; no register bus
`timescale 1ns/1ps
module reset_source_and_clock_select #(
  parameter int unsigned STRETCH = rst_pkg::STRETCH_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       supply_low_i,
  input  wire logic       wdog_expired_i,
  input  wire logic       clk_missing_i,
  input  wire logic       cmp0_low_i,
  input  wire logic       soft_reset_i,
  input  wire logic       reset_pin_i,
  input  wire logic       supply_monitor_enable_pin_i,
  input  wire logic [3:0] src_enable_i,
  input  wire logic       wdog_lock_i,
  input  wire logic       clk_ext_req_i,
  output logic            reset_pin_o,
  output logic            reset_pin_oe_o,
  output logic            sys_reset_o,
  output logic            wdog_locked_o,
  output logic [5:0]      reset_cause_o,
  output logic            clk_sel_o
);
  typedef enum logic [1:0] {IDLE, HOLD, STRETCH_ST} rst_state_t;

  logic       rs1;
  logic       rs2;
  logic       rst_n;
  rst_sync_if sync ();

  // Two-stage release of the external asynchronous reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rs1 <= 1'h0;
      rs2 <= 1'h0;
    end else begin
      rs1 <= 1'h1;
      rs2 <= rs1;
    end
  end
  assign rst_n = rs2;

  pin_filter u_filt (
    .clk_i       (clk_i),
    .rst_n       (rst_n),
    .pin_rst_n_i (reset_pin_i),
    .mon_en_i    (supply_monitor_enable_pin_i),
    .sync        (sync)
  );

  rst_state_t  state;
  rst_state_t  next_state;
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic        drive;
  logic        next_drive;
  logic        sysr;
  logic        next_sysr;
  logic        locked;
  logic        next_locked;
  logic        lock_window;
  logic        next_lock_window;
  logic        csel;
  logic        next_csel;
  logic [5:0]  cause;
  logic [5:0]  next_cause;
  logic [5:0]  raw;
  logic [5:0]  en;
  logic [5:0]  act;
  logic        internal;
  logic        any;
  logic [rst_pkg::ECHO_CYC-1:0] pin_echo;
  logic [rst_pkg::ECHO_CYC-1:0] next_pin_echo;

  // Gather raw sources into one vector
  always_comb begin
    raw = '0;
    raw[rst_pkg::SRC_SUPPLY] = supply_low_i & sync.mon_en;
    raw[rst_pkg::SRC_WDOG]   = wdog_expired_i;
    raw[rst_pkg::SRC_MCLK]   = clk_missing_i;
    raw[rst_pkg::SRC_CMP0]   = cmp0_low_i;
    raw[rst_pkg::SRC_SOFT]   = soft_reset_i;
    // Own drive and its filter echo are excluded, so releasing the pin
    // cannot start a second reset while the filter still sees it low
    raw[rst_pkg::SRC_PIN]    = sync.pin_rst & ~drive & ~(|pin_echo);
  end

  // Unmaskable bits forced on; watchdog forced on while locked
  always_comb begin
    en = ~rst_pkg::MASKABLE | ({1'h0, src_enable_i, 1'h0} & rst_pkg::MASKABLE);
    if (locked) begin
      en[rst_pkg::SRC_WDOG] = 1'h1;
    end
    act      = raw & en;
    internal = |(act & ~(6'h01 << rst_pkg::SRC_PIN));
    any      = |act;
  end

  // Reset sequencer: hold while any source active, then stretch pin drive
  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_drive       = drive;
    next_sysr        = any;
    next_cause       = cause;
    next_locked      = locked;
    next_lock_window = lock_window;
    next_csel        = csel;
    next_pin_echo    = {pin_echo[rst_pkg::ECHO_CYC-2:0], drive};
    case (state)
      IDLE: begin
        if (any) begin
          next_state = HOLD;
          next_cause = act;
        end
      end
      HOLD: begin
        next_sysr  = 1'h1; // Stays up into the stretch, no gap
        next_cause = cause | act;
        next_drive = internal | drive;
        if (!any) begin
          next_state = STRETCH_ST;
          next_cnt   = 8'(STRETCH);
        end
      end
      STRETCH_ST: begin
        next_sysr = 1'h1;
        if (any) begin
          next_state = HOLD;
        end else if (cnt <= 8'h01) begin
          next_state       = IDLE;
          next_drive       = 1'h0;
          next_sysr        = 1'h0;
          next_lock_window = 1'h1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = IDLE;
    endcase
    // Any reset returns to the internal oscillator
    if (next_sysr) begin
      next_csel = rst_pkg::CLK_INT;
    end else begin
      next_csel = clk_ext_req_i ? rst_pkg::CLK_EXT : rst_pkg::CLK_INT;
    end
    // Lock allowed in any run once the first reset sequence ends; cleared by sync reset
    if (!next_sysr && lock_window && wdog_lock_i) begin
      next_locked = 1'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= HOLD;
      cnt         <= 8'h00;
      drive       <= 1'h1;
      sysr        <= 1'h1;
      locked      <= 1'h0;
      lock_window <= 1'h0;
      csel        <= rst_pkg::CLK_INT;
      cause       <= 6'h00;
      pin_echo    <= '1;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      drive       <= next_drive;
      sysr        <= next_sysr;
      locked      <= next_locked;
      lock_window <= next_lock_window;
      csel        <= next_csel;
      cause       <= next_cause;
      pin_echo    <= next_pin_echo;
    end
  end

  // Pin driven low only while asserting; released otherwise
  assign reset_pin_o    = 1'h0;
  assign reset_pin_oe_o = drive;
  assign sys_reset_o    = sysr;
  assign wdog_locked_o  = locked;
  assign reset_cause_o  = cause;
  assign clk_sel_o      = csel;

  property p_or_holds;
    @(posedge clk_i) disable iff (!rst_n) any |=> sys_reset_o;
  endproperty
  a_or_holds: assert property (p_or_holds) else $error("reset dropped");

  property p_clk_int;
    @(posedge clk_i) disable iff (!rst_n) sys_reset_o |-> clk_sel_o == 1'h0;
  endproperty
  a_clk_int: assert property (p_clk_int) else $error("ext clk in reset");

  property p_clk_sw;
    @(posedge clk_i) disable iff (!rst_n)
      (!next_sysr && clk_ext_req_i) |=> clk_sel_o;
  endproperty
  a_clk_sw: assert property (p_clk_sw) else $error("no clock switch");

  property p_lock_sticky;
    @(posedge clk_i) disable iff (!rst_n) locked |=> locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock lost");

  property p_wdog_locked;
    @(posedge clk_i) disable iff (!rst_n)
      (locked && wdog_expired_i) |=> sys_reset_o;
  endproperty
  a_wdog_locked: assert property (p_wdog_locked) else $error("wdog masked");

  property p_supply;
    @(posedge clk_i) disable iff (!rst_n)
      (supply_low_i && sync.mon_en) |=> sys_reset_o;
  endproperty
  a_supply: assert property (p_supply) else $error("supply masked");

  property p_mask;
    @(posedge clk_i) disable iff (!rst_n)
      (state == IDLE && !sync.pin_rst && !supply_low_i && !locked &&
       src_enable_i == 4'h0) |=> !sys_reset_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked source reset");

  property p_pin_drive;
    @(posedge clk_i) disable iff (!rst_n)
      (state == HOLD && internal) |=> reset_pin_oe_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

  property p_src_cause;
    @(posedge clk_i) disable iff (!rst_n)
      (state == IDLE && act[rst_pkg::SRC_SOFT]) |=> cause[rst_pkg::SRC_SOFT];
  endproperty
  a_src_cause: assert property (p_src_cause) else $error("cause lost");

  c_soft: cover property (@(posedge clk_i) disable iff (!rst_n)
    act[rst_pkg::SRC_SOFT] ##1 sys_reset_o);
  c_ext: cover property (@(posedge clk_i) disable iff (!rst_n) clk_sel_o);
  c_lock: cover property (@(posedge clk_i) disable iff (!rst_n) locked);
endmodule

// >>> verif/reset_board.sv
// Purpose: Board side of the reset pin and the supply monitor strap
// Assumes: Reset pin is open drain with a board pull-up
// Notes:   Released pin reads high through the pull-up
`timescale 1ns/1ps
module reset_board (
  input  wire logic pin_oe_i,
  input  wire logic pin_val_i,
  input  wire logic ext_pull_i,
  input  wire logic strap_on_i,
  output logic      pin_level_o,
  output logic      strap_o
);
  // Wired-AND of device drive and outside pull; pull-up when released
  assign pin_level_o = (pin_oe_i ? pin_val_i : 1'b1) & ~ext_pull_i;
  // Strap tied high enables the supply source
  assign strap_o = strap_on_i;
endmodule

// >>> verif/reset_source_and_clock_select_tb.sv
// Purpose: Self-checking bench for the reset combiner and clock select
// Assumes: Default stretch; sources driven as levels
// Notes:   Model predicts reset from trips, enables, lock and strap
`timescale 1ns/1ps
module reset_source_and_clock_select_tb;
  logic       clk_i;
  logic       nrst_i;
  logic       supply_low_i;
  logic       wdog_expired_i;
  logic       clk_missing_i;
  logic       cmp0_low_i;
  logic       soft_reset_i;
  logic       ext_pull;
  logic       strap_on;
  logic       wdog_lock_i;
  logic       clk_ext_req_i;
  logic [3:0] src_enable_i;
  logic       reset_pin_o;
  logic       reset_pin_oe_o;
  logic       sys_reset_o;
  logic       wdog_locked_o;
  logic       clk_sel_o;
  logic       pin_level;
  logic       strap;
  logic [5:0] reset_cause_o;
  logic [5:0] trip;
  int         bad_count;
  int         compares;
  int         seed;
  int         n;
  int         r;
  bit         locked;

  // Trip vector uses the package source positions
  assign supply_low_i   = trip[rst_pkg::SRC_SUPPLY];
  assign wdog_expired_i = trip[rst_pkg::SRC_WDOG];
  assign clk_missing_i  = trip[rst_pkg::SRC_MCLK];
  assign cmp0_low_i     = trip[rst_pkg::SRC_CMP0];
  assign soft_reset_i   = trip[rst_pkg::SRC_SOFT];
  assign ext_pull       = trip[rst_pkg::SRC_PIN];

  reset_source_and_clock_select i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .supply_low_i(supply_low_i),
    .wdog_expired_i(wdog_expired_i), .clk_missing_i(clk_missing_i),
    .cmp0_low_i(cmp0_low_i), .soft_reset_i(soft_reset_i),
    .reset_pin_i(pin_level), .supply_monitor_enable_pin_i(strap),
    .src_enable_i(src_enable_i), .wdog_lock_i(wdog_lock_i),
    .clk_ext_req_i(clk_ext_req_i), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_o(reset_pin_oe_o), .sys_reset_o(sys_reset_o),
    .wdog_locked_o(wdog_locked_o), .reset_cause_o(reset_cause_o),
    .clk_sel_o(clk_sel_o)
  );

  reset_board i_board (
    .pin_oe_i(reset_pin_oe_o), .pin_val_i(reset_pin_o),
    .ext_pull_i(ext_pull), .strap_on_i(strap_on),
    .pin_level_o(pin_level), .strap_o(strap)
  );

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Pin unmaskable, supply gated by the strap only; lock forces the watchdog enable
  function automatic bit model(logic [5:0] t, logic [3:0] e, bit lk,
                               logic st);
    logic [5:0] m;
    m = {1'b1, e, st};
    if (lk) m[1] = 1'b1;
    return |(t & m);
  endfunction

  task automatic check(string name, logic [5:0] seen, logic [5:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("Mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic step(int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Bounded wait for the internal reset to end
  task automatic settle();
    for (n = 0; n < 60 && sys_reset_o !== 1'b0; n++) @(negedge clk_i);
    if (n == 60) begin
      bad_count++;
      $display("Error settle expected 0 seen %b", sys_reset_o);
      results();
    end
  endtask

  // One source tripped under given enables and strap
  task automatic trial(int s, logic [3:0] e, logic st);
    bit x;
    @(posedge clk_i);
    src_enable_i <= e;
    strap_on     <= st;
    step(6);
    trip[s] <= 1'b1;
    step(8);
    @(negedge clk_i);
    x = model(6'h01 << s, e, locked, st);
    check("sys_reset", sys_reset_o, x);
    if (x) check("cause", reset_cause_o[s], 1);
    if (x && s != 5) check("pin_oe", reset_pin_oe_o, 1);
    check("pin_val", reset_pin_o, 0);
    @(posedge clk_i);
    trip[s] <= 1'b0;
    settle();
    check("pin_oe_idle", reset_pin_oe_o, 0);
    check("clk_sel", clk_sel_o, rst_pkg::CLK_INT);
    // Released pin must not echo back as a fresh reset
    step(8);
    @(negedge clk_i);
    check("no_echo", sys_reset_o, 0);
  endtask

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    trip = 6'h00;
    strap_on = 1'b1;
    wdog_lock_i = 1'b0;
    clk_ext_req_i = 1'b0;
    src_enable_i = 4'hF;
    bad_count = 0;
    compares = 0;
    seed = 32'h55BA2ACC;
    locked = 1'b0;
    step(6);
    nrst_i <= 1'b1;
    settle();
    check("clk_sel_boot", clk_sel_o, rst_pkg::CLK_INT);
    check("locked_boot", wdog_locked_o, 0);
    // Every source under random enables and strap
    for (int i = 0; i < 18; i++) begin
      r = $random(seed);
      trial(i % 6, r[3:0], r[4]);
    end
    // Reset holds while a second source stays active
    @(posedge clk_i);
    src_enable_i <= 4'hF;
    strap_on     <= 1'b1;
    trip <= 6'h11;
    step(8);
    trip <= 6'h01;
    step(8);
    @(negedge clk_i);
    check("hold", sys_reset_o, 1);
    @(posedge clk_i);
    trip <= 6'h00;
    settle();
    // Switch to external oscillator on the fly, then reset
    @(posedge clk_i);
    clk_ext_req_i <= 1'b1;
    step(3);
    @(negedge clk_i);
    check("clk_ext", clk_sel_o, rst_pkg::CLK_EXT);
    @(posedge clk_i);
    trip <= 6'h10;
    step(2);
    @(negedge clk_i);
    check("clk_in_rst", clk_sel_o, rst_pkg::CLK_INT);
    @(posedge clk_i);
    clk_ext_req_i <= 1'b0;
    step(5);
    trip <= 6'h00;
    settle();
    check("clk_after", clk_sel_o, rst_pkg::CLK_INT);
    // Lock watchdog, then a masked watchdog trip must still reset
    @(posedge clk_i);
    wdog_lock_i <= 1'b1;
    step(3);
    wdog_lock_i <= 1'b0;
    @(negedge clk_i);
    check("locked", wdog_locked_o, 1);
    locked = 1'b1;
    trial(1, 4'h0, 1'b1);
    check("locked_end", wdog_locked_o, 1);
    results();
  end
endmodule
